/* File: rtl/mpx_pkg.sv */
// shared constants of the media port in external-clock mode
// assumes a single system clock domain; the link clock is a sampled pin
package mpx_pkg;
   localparam int DATA_W   = 16;
   localparam int TX_DEPTH = 8;
   localparam int RX_DEPTH = 8;
   localparam int CLK_MHZ  = 100;
   // request falls one system clock after the pop that empties the tx queue
   localparam int REQ_DROP_CYC = 1;
endpackage : mpx_pkg

/* File: rtl/mpx_queue.sv */
// flip-flop queue with valid/ready on both sides
// assumes one clock; push and pop may coincide
`timescale 1ns/100ps
module mpx_queue #(
   parameter int W = 16,
   parameter int D = 8
) (
   // clock and reset
   input  wire logic         mclk,
   input  wire logic         rst_n,
   // fill side
   input  wire logic         inValid,
   output logic              inReady,
   input  wire logic [W-1:0] inData,
   // drain side
   output logic              outValid,
   input  wire logic         outReady,
   output logic [W-1:0]      outData,
   // status
   output logic              full,
   output logic              empty
);
   localparam int AW = $clog2(D);
   logic [W-1:0]  mem_r [D];
   logic [AW-1:0] wrPtr_r;
   logic [AW-1:0] rdPtr_r;
   logic [AW:0]   count_r;
   wire           push = inValid && inReady;
   wire           pop  = outValid && outReady;

   assign full     = (count_r == (AW+1)'(D));
   assign empty    = (count_r == '0);
   assign inReady  = !full;
   assign outValid = !empty;
   assign outData  = mem_r[rdPtr_r];

   always_ff @(posedge mclk) begin
      if (push) mem_r[wrPtr_r] <= inData;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
         count_r <= '0;
      end else begin
         if (push) wrPtr_r <= (wrPtr_r == AW'(D-1)) ? '0 : wrPtr_r + 1'b1;
         if (pop)  rdPtr_r <= (rdPtr_r == AW'(D-1)) ? '0 : rdPtr_r + 1'b1;
         count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // mpx_queue

/* File: rtl/mpx_port.sv */
// media port, external-clock mode: far device clocks reads and writes
// assumes the processor side fills tx and drains rx on mclk
`timescale 1ns/100ps
module mpx_port
#(
   parameter int W  = mpx_pkg::DATA_W,
   parameter int TD = mpx_pkg::TX_DEPTH,
   parameter int RD = mpx_pkg::RX_DEPTH
) (
   // clock and reset
   input  wire logic         mclk,
   input  wire logic         rst_n,
   // mode control
   input  wire logic         mediaDeviceModeSelect,
   input  wire logic         clockDriveSelect,
   // link pins
   input  wire logic         portClockSelect,
   input  wire logic         hostWriteSelect,
   input  wire logic [W-1:0] dataIn,
   output logic [W-1:0]      dataOut,
   output logic              dataOe,
   output logic              txDataRequest,
   // processor side: transmit fill
   input  wire logic         txValid,
   output logic              txReady,
   input  wire logic [W-1:0] txData,
   // processor side: receive drain
   output logic              rxValid,
   input  wire logic         rxReady,
   output logic [W-1:0]      rxData,
   // events
   output logic              rxOverflow
);
   import mpx_pkg::*;

   // stages between the queue level and the request pin
   localparam int DROP = REQ_DROP_CYC;

   // link synchronisers
   logic [1:0]      clkSync_r;
   logic [1:0]      wrSync_r;
   logic [W-1:0]    dSync0_r;
   logic [W-1:0]    dSync1_r;
   logic            clkPrev_r;

   // read drive
   logic [W-1:0]    dataOut_r;
   logic [W-1:0]    dataOut_nxt;
   logic            dataOe_r;
   logic            dataOe_nxt;

   // request and overflow
   logic [DROP-1:0] reqPipe_r;
   logic            ovf_r;
   logic            ovf_nxt;

   // queue status
   logic            txQValid;
   logic [W-1:0]    txQData;
   logic            txEmpty;
   logic            rxFull;
   logic            rxInReady;

   // decoded link events
   logic            extMode;
   logic            clkRise;
   logic            readCyc;
   logic            writeCyc;
   logic            txPop;
   logic            rxPush;
   logic            rxLost;
   logic            reqLevel;

   // external-clock mode only when pins are inputs
   assign extMode  = mediaDeviceModeSelect && !clockDriveSelect;
   assign clkRise  = extMode && clkSync_r[1] && !clkPrev_r;
   assign readCyc  = clkRise && wrSync_r[1];
   assign writeCyc = clkRise && !wrSync_r[1];
   // a read with nothing queued pops nothing and drives the last word again
   assign txPop    = readCyc && txQValid;
   assign rxPush   = writeCyc && rxInReady;
   assign rxLost   = writeCyc && rxFull;
   // the request follows the queue level only while the pins are inputs
   assign reqLevel = extMode && !txEmpty;

   // link clock: two flops against metastability
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         clkSync_r <= '0;
      end else begin
         clkSync_r <= {clkSync_r[0], portClockSelect};
      end
   end

   // resets low like the idle pin, so reset release makes no false edge
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         clkPrev_r <= 1'b0;
      end else begin
         clkPrev_r <= clkSync_r[1];
      end
   end

   // write select takes the same depth, so it lines up with the edge
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wrSync_r <= '0;
      end else begin
         wrSync_r <= {wrSync_r[0], hostWriteSelect};
      end
   end

   // per-bit data stage of the same depth; the far end holds the word steady
   // around its clock rise, so the bits settle together without gray coding
   for (genvar b = 0; b < W; b++) begin : g_dataSync
      always_ff @(posedge mclk or negedge rst_n) begin
         if (!rst_n) begin
            dSync0_r[b] <= 1'b0;
            dSync1_r[b] <= 1'b0;
         end else begin
            dSync0_r[b] <= dataIn[b];
            dSync1_r[b] <= dSync0_r[b];
         end
      end
   end

   // a detected rise decides the drive; leaving the mode releases the bus
   assign dataOe_nxt  = clkRise ? readCyc  :
                        extMode ? dataOe_r :
                                  1'b0;
   // data moves only on a pop; a refused read leaves the last word standing
   assign dataOut_nxt = txPop ? txQData : dataOut_r;
   // one pulse per lost write; the flag follows rxLost each clock with no clear input, so no set/clear race
   assign ovf_nxt     = rxLost;

   // registered so the pins never glitch between link edges
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         dataOe_r <= 1'b0;
      end else begin
         dataOe_r <= dataOe_nxt;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         dataOut_r <= '0;
      end else begin
         dataOut_r <= dataOut_nxt;
      end
   end

   // the emptying pop lands on one edge; the first stage sees it one clock later
   for (genvar s = 0; s < DROP; s++) begin : g_reqPipe
      if (s == 0) begin : g_first
         always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
               reqPipe_r[s] <= 1'b0;
            end else begin
               reqPipe_r[s] <= reqLevel;
            end
         end
      end else begin : g_next
         always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
               reqPipe_r[s] <= 1'b0;
            end else begin
               reqPipe_r[s] <= reqPipe_r[s-1];
            end
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ovf_r <= 1'b0;
      end else begin
         ovf_r <= ovf_nxt;
      end
   end

   assign dataOut       = dataOut_r;
   assign dataOe        = dataOe_r;
   assign txDataRequest = reqPipe_r[DROP-1];
   assign rxOverflow    = ovf_r;

   mpx_queue #(.W(W), .D(TD)) txQueue (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .inValid  (txValid),
      .inReady  (txReady),
      .inData   (txData),
      .outValid (txQValid),
      .outReady (txPop),
      .outData  (txQData),
      .full     (),
      .empty    (txEmpty)
   );

   // rx drain is assumed faster than the link fills it
   mpx_queue #(.W(W), .D(RD)) rxQueue (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .inValid  (rxPush),
      .inReady  (rxInReady),
      .inData   (dSync1_r),
      .outValid (rxValid),
      .outReady (rxReady),
      .outData  (rxData),
      .full     (rxFull),
      .empty    ()
   );
endmodule // mpx_port

/* File: sim/mpx_port_asserts.sv */
// link checks for mpx_port
// bound from the bench top; sees the top ports only
`timescale 1ns/100ps
module mpx_port_asserts (
   // clock and reset
   input wire logic        mclk,
   input wire logic        rst_n,
   // mode and link pins
   input wire logic        mediaDeviceModeSelect,
   input wire logic        clockDriveSelect,
   input wire logic        portClockSelect,
   input wire logic        hostWriteSelect,
   input wire logic        dataOe,
   input wire logic        txDataRequest,
   // processor side
   input wire logic        txValid,
   input wire logic        txReady,
   input wire logic        rxValid,
   input wire logic        rxReady,
   input wire logic        rxOverflow,
   input wire logic [15:0] rxData
);
   wire  ext = mediaDeviceModeSelect & ~clockDriveSelect;
   // helper: a read-cycle rise of the link clock as seen at an mclk sample
   logic pinPrev_r;
   wire  rdEdge = portClockSelect && !pinPrev_r && hostWriteSelect && ext;
   always_ff @(posedge mclk) pinPrev_r <= portClockSelect;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   property p_mode; !ext [*2] |-> !dataOe; endproperty
   a_mode: assert property (p_mode) else $error("oe high outside mode");
   property p_req; txValid && txReady && ext |-> ##[1:3] txDataRequest; endproperty
   a_req: assert property (p_req) else $error("request missing");
   property p_rd; $rose(portClockSelect) && hostWriteSelect && ext |-> ##[2:4] dataOe; endproperty
   a_rd: assert property (p_rd) else $error("read not driven");
   property p_wr; $rose(portClockSelect) && !hostWriteSelect && ext |-> ##[2:4] !dataOe; endproperty
   a_wr: assert property (p_wr) else $error("oe high on write");
   // two sync flops, edge detect, pop, then one clock: the fall is four samples after the rise
   property p_drop; $fell(txDataRequest) |-> $past(rdEdge, 4); endproperty
   a_drop: assert property (p_drop) else $error("request fell without read");
   property p_ovf; rxOverflow |-> rxValid ##1 !rxOverflow; endproperty
   a_ovf: assert property (p_ovf) else $error("bad overflow pulse");
   property p_keep; rxOverflow && !rxReady |-> $stable(rxData); endproperty
   a_keep: assert property (p_keep) else $error("held data changed");
   property p_acc; $rose(portClockSelect) && !hostWriteSelect && ext && !rxValid |-> ##[2:5] rxValid; endproperty
   a_acc: assert property (p_acc) else $error("write not stored");
   c_drop: cover property ($fell(txDataRequest));
   c_ovf: cover property (rxOverflow);
   c_full: cover property (ext && !txReady);
endmodule // mpx_port_asserts

/* File: sim/mpx_far_model.sv */
// far media device: makes the link clock, write select and write data
// link clock stands low between cycles; idle data inverts the last word
`timescale 1ns/100ps
module mpx_far_model (
   // link pins
   output logic            portClockSelect,
   output logic            hostWriteSelect,
   output logic [15:0]     dataIn,
   // device side
   input wire logic [15:0] dataOut,
   input wire logic        dataOe,
   input wire logic        txDataRequest
);
   initial begin
      portClockSelect = 1'b0;
      hostWriteSelect = 1'b1;
      dataIn = 16'h0000;
   end
   task automatic cyc(input logic wr, input logic [15:0] d);
      hostWriteSelect = !wr;
      dataIn = d;
      #80 portClockSelect = 1'b1;
      #80 portClockSelect = 1'b0;
      dataIn = ~d;
   endtask
   // never reads with the request low, so a refused read returns unknown
   task automatic rd(output logic [15:0] d);
      d = 16'hxxxx;
      if (txDataRequest === 1'b1) begin
         cyc(1'b0, ~dataIn);
         d = dataOe ? dataOut : 16'hxxxx;
      end
   endtask
endmodule // mpx_far_model

/* File: sim/mpx_port_tb_top.sv */
// bench for mpx_port in external-clock mode
// far model drives the link; bench drives mode bits and processor side
`timescale 1ns/100ps
module mpx_port_tb_top;
   import mpx_pkg::*;
   logic        mclk = 1'b0, rst_n = 1'b0, mediaDeviceModeSelect = 1'b1, clockDriveSelect = 1'b0, ovfSeen = 1'b0;
   logic        txValid = 1'b0, rxReady = 1'b0, txReady, rxValid, rxOverflow, dataOe, txDataRequest;
   logic        portClockSelect, hostWriteSelect;
   logic [15:0] dataIn, dataOut, txData = 16'h0000, rxData, v;
   int          failures = 0, n_compared = 0, cyc = 0;
   always #5 mclk = ~mclk;
   always @(posedge mclk) if (rxOverflow === 1'b1) ovfSeen <= 1'b1;
   mpx_port dut (.mclk(mclk), .rst_n(rst_n), .mediaDeviceModeSelect(mediaDeviceModeSelect),
      .clockDriveSelect(clockDriveSelect), .portClockSelect(portClockSelect), .hostWriteSelect(hostWriteSelect),
      .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .txDataRequest(txDataRequest), .txValid(txValid),
      .txReady(txReady), .txData(txData), .rxValid(rxValid), .rxReady(rxReady), .rxData(rxData),
      .rxOverflow(rxOverflow));
   mpx_far_model u_far (.portClockSelect(portClockSelect), .hostWriteSelect(hostWriteSelect), .dataIn(dataIn),
      .dataOut(dataOut), .dataOe(dataOe), .txDataRequest(txDataRequest));
   task chk(input string n, input logic [15:0] s, input logic [15:0] e);
      n_compared++;
      if (s !== e) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task end_of_test;
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         failures++;
         end_of_test();
      end
   end
   task t_tx;
      for (int i = 0; i < TX_DEPTH; i++) begin
         txData = 16'(16'ha500 + i);
         txValid = 1'b1;
         @(posedge mclk);
         #1;
      end
      txValid = 1'b0;
      chk("txReady", 16'(txReady), 16'h0000);
      for (int i = 0; i < TX_DEPTH; i++) begin
         chk("request", 16'(txDataRequest), 16'h0001);
         u_far.rd(v);
         chk("read", v, 16'(16'ha500 + i));
      end
      chk("request low", 16'(txDataRequest), 16'h0000);
      $display("t_tx done");
   endtask
   task t_rx;
      for (int i = 0; i < RX_DEPTH + 1; i++) u_far.cyc(1'b1, 16'(16'h5a00 + i));
      chk("overflow", 16'(ovfSeen), 16'h0001);
      rxReady = 1'b1;
      for (int i = 0; i < RX_DEPTH; i++) begin
         chk("rx", rxData, 16'(16'h5a00 + i));
         @(posedge mclk);
         #1;
      end
      chk("dropped", 16'(rxValid), 16'h0000);
      rxReady = 1'b0;
      $display("t_rx done");
   endtask
   task t_mode;
      clockDriveSelect = 1'b1;
      u_far.cyc(1'b1, 16'h0f0f);
      chk("ignored", 16'(rxValid), 16'h0000);
      clockDriveSelect = 1'b0;
      $display("t_mode done");
   endtask
   initial begin
      repeat (12) @(posedge mclk);
      #1 rst_n = 1'b1;
      @(posedge mclk);
      #1;
      t_tx;
      t_rx;
      t_mode;
      end_of_test;
   end
endmodule // mpx_port_tb_top
bind mpx_port mpx_port_asserts u_chk (.*);
